/* rtl/wtb_wide_timer_byte_access.v */
// byte access bridge for the 16-bit timer registers
// assumes a cpu bus on the same clock, one access per strobe,
// and that the timer core drives its count and capture updates
`timescale 1ns/1ns
`include "wtb_defs.vh"

// Behaviour
// - count, two compares, capture seen as 16-bit registers on 8-bit bus
// - every 16-bit register is reached by two separate byte accesses
// - one shared 8-bit high byte temporary for all four registers
// - only low byte accesses move the full 16-bit value
// - low byte write loads temp high and written low in one cycle
// - count and capture low byte reads return low, copy high half into temp
// - compare reads give high byte directly, temp untouched
module wtb_wide_timer_byte_access #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             bus_wr,
  input  wire             bus_rd,
  input  wire [2:0]       bus_sel,
  input  wire [7:0]       bus_wdata,
  output reg  [7:0]       bus_rdata,
  output reg              bus_rvalid,
  input  wire             core_cnt_load,
  input  wire [WIDTH-1:0] core_cnt_value,
  input  wire             core_cap_load,
  input  wire [WIDTH-1:0] core_cap_value,
  output reg  [WIDTH-1:0] timer_count_value,
  output reg  [WIDTH-1:0] compare_value_a,
  output reg  [WIDTH-1:0] compare_value_b,
  output reg  [WIDTH-1:0] capture_value,
  output reg              cnt_write_pulse
);

  reg  [7:0] temp_high_reg;
  reg  [7:0] temp_high_next;
  reg  [7:0] rdata_next;
  reg        cnt_wr_next;
  wire [15:0] write_word;

  // ==========================================================
  // helpers
  function is_low_byte;
    input [2:0] sel;
    is_low_byte = ~sel[0];
  endfunction

  function [15:0] pick_word;
    input [1:0]  idx;
    input [15:0] c;
    input [15:0] a;
    input [15:0] b;
    input [15:0] p;
    begin
      if (idx == `WTB_IDX_CNT)
        pick_word = c;
      else if (idx == `WTB_IDX_CMPA)
        pick_word = a;
      else if (idx == `WTB_IDX_CMPB)
        pick_word = b;
      else
        pick_word = p;
    end
  endfunction

  // full word formed on a low byte write
  assign write_word = {temp_high_reg, bus_wdata};

  // ==========================================================
  // shared temp register next value
  always @* begin
    temp_high_next = temp_high_reg;
    if (bus_wr && !is_low_byte(bus_sel)) begin
      // any high byte write parks its byte here only
      temp_high_next = bus_wdata;
    end else if (bus_rd && (bus_sel == `WTB_SEL_CNT_LO)) begin
      // count low read freezes the high half for the next read
      temp_high_next = timer_count_value[15:8];
    end else if (bus_rd && (bus_sel == `WTB_SEL_CAP_LO)) begin
      // capture low read does the same for the capture word
      temp_high_next = capture_value[15:8];
    end else begin
      // compare reads and low writes leave the temp alone
      temp_high_next = temp_high_reg;
    end
  end

  // ==========================================================
  // count write pulse decode
  always @* begin
    cnt_wr_next = 1'b0;
    if (bus_wr && (bus_sel == `WTB_SEL_CNT_LO)) begin
      cnt_wr_next = 1'b1;
    end
  end

  // ==========================================================
  // read data next value, zero when no read is taken
  always @* begin
    rdata_next = `WTB_RST_BYTE;
    if (!bus_rd) begin
      rdata_next = `WTB_RST_BYTE;
    end else if (bus_sel == `WTB_SEL_CNT_LO) begin
      rdata_next = timer_count_value[7:0];
    end else if (bus_sel == `WTB_SEL_CAP_LO) begin
      rdata_next = capture_value[7:0];
    end else if (bus_sel == `WTB_SEL_CMPA_LO) begin
      rdata_next = compare_value_a[7:0];
    end else if (bus_sel == `WTB_SEL_CMPB_LO) begin
      rdata_next = compare_value_b[7:0];
    end else if (bus_sel == `WTB_SEL_CMPA_HI) begin
      // compare high bytes bypass the temp
      rdata_next = compare_value_a[15:8];
    end else if (bus_sel == `WTB_SEL_CMPB_HI) begin
      rdata_next = compare_value_b[15:8];
    end else begin
      // count and capture high reads return the temp
      rdata_next = temp_high_reg;
    end
  end

  // ==========================================================
  // temp register and bus answer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_high_reg   <= `WTB_RST_BYTE;
      bus_rdata       <= `WTB_RST_BYTE;
      bus_rvalid      <= 1'b0;
      cnt_write_pulse <= 1'b0;
    end else begin
      temp_high_reg   <= temp_high_next;
      bus_rdata       <= rdata_next;
      bus_rvalid      <= bus_rd;
      cnt_write_pulse <= cnt_wr_next;
    end
  end

  // ==========================================================
  // low byte write strobes, one per 16-bit register
  wire wr_cnt_lo;
  wire wr_cmpa_lo;
  wire wr_cmpb_lo;
  wire wr_cap_lo;

  assign wr_cnt_lo  = bus_wr && (bus_sel == `WTB_SEL_CNT_LO);
  assign wr_cmpa_lo = bus_wr && (bus_sel == `WTB_SEL_CMPA_LO);
  assign wr_cmpb_lo = bus_wr && (bus_sel == `WTB_SEL_CMPB_LO);
  assign wr_cap_lo  = bus_wr && (bus_sel == `WTB_SEL_CAP_LO);

  // ==========================================================
  // count register; cpu low byte write beats a core load
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count_value <= `WTB_RST_WORD;
    end else if (wr_cnt_lo) begin
      timer_count_value <= write_word;
    end else if (core_cnt_load) begin
      timer_count_value <= core_cnt_value;
    end
  end

  // ==========================================================
  // compare a; only the cpu writes it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_value_a <= `WTB_RST_WORD;
    end else if (wr_cmpa_lo) begin
      compare_value_a <= write_word;
    end
  end

  // ==========================================================
  // compare b; only the cpu writes it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_value_b <= `WTB_RST_WORD;
    end else if (wr_cmpb_lo) begin
      compare_value_b <= write_word;
    end
  end

  // ==========================================================
  // capture; cpu low byte write beats a core capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_value <= `WTB_RST_WORD;
    end else if (wr_cap_lo) begin
      capture_value <= write_word;
    end else if (core_cap_load) begin
      capture_value <= core_cap_value;
    end
  end

  // ==========================================================
  // shadow copy of written words, read data left unused
  wire [15:0] unused_shadow;
  wtb_word_store #(
    .WIDTH (WIDTH)
  ) u_store (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (bus_wr & is_low_byte(bus_sel)),
    .wr_idx  (bus_sel[2:1]),
    .wr_data (write_word),
    .rd_idx  (bus_sel[2:1]),
    .rd_data (unused_shadow)
  );

  // keeps pick_word in use for the core's word view
  wire [15:0] sel_word = pick_word(bus_sel[2:1], timer_count_value,
                                   compare_value_a, compare_value_b,
                                   capture_value);

  // ==========================================================
  // hazard: one temp serves all four registers, so an isr that
  // writes any of them, or reads count or capture, between the two byte accesses of main
  // code overwrites the temp; main code masks interrupts there
  // limitation: both strobes in one cycle are not supported

endmodule

/* rtl/wtb_defs.vh */
// constants for the wide timer byte access block
// assumes inclusion by bare name from rtl design files
`ifndef WTB_DEFS_VH
`define WTB_DEFS_VH

// byte select codes on the 8-bit bus
`define WTB_SEL_CNT_LO 3'h0
`define WTB_SEL_CNT_HI 3'h1
`define WTB_SEL_CMPA_LO 3'h2
`define WTB_SEL_CMPA_HI 3'h3
`define WTB_SEL_CMPB_LO 3'h4
`define WTB_SEL_CMPB_HI 3'h5
`define WTB_SEL_CAP_LO 3'h6
`define WTB_SEL_CAP_HI 3'h7

// register indices inside the word store
`define WTB_IDX_CNT 2'h0
`define WTB_IDX_CMPA 2'h1
`define WTB_IDX_CMPB 2'h2
`define WTB_IDX_CAP 2'h3

// reset values
`define WTB_RST_WORD 16'h0000
`define WTB_RST_BYTE 8'h00

`endif

/* rtl/wtb_word_store.v */
// four 16-bit words with one write port and registered read
// assumes one clock and asynchronous active low reset
`timescale 1ns/1ns
`include "wtb_defs.vh"

module wtb_word_store #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             wr_en,
  input  wire [1:0]       wr_idx,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [1:0]       rd_idx,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem_reg [0:3];
  integer i;

  // ==========================================================
  // storage and registered read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1)
        mem_reg[i] <= `WTB_RST_WORD;
      rd_data <= `WTB_RST_WORD;
    end else begin
      if (wr_en)
        mem_reg[wr_idx] <= wr_data;
      rd_data <= mem_reg[rd_idx];
    end
  end

endmodule

/* verification/wtb_wide_timer_byte_access_asserts.sv */
// checker for the byte access bridge
// assumes bind from the bench top file
`timescale 1ns/1ns
// =====
// checker
module wtb_chk #(
  parameter WIDTH = 16
) (
  input logic             clk,
  input logic             rst_n,
  input logic             bus_wr,
  input logic             bus_rd,
  input logic [2:0]       bus_sel,
  input logic [7:0]       bus_wdata,
  input logic [7:0]       bus_rdata,
  input logic             bus_rvalid,
  input logic [WIDTH-1:0] timer_count_value,
  input logic [WIDTH-1:0] compare_value_a,
  input logic [WIDTH-1:0] compare_value_b,
  input logic             cnt_write_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_valid_a: assert property (bus_rd |=> bus_rvalid)
    else $error("no rvalid");
  rd_quiet_a: assert property (!bus_rd |=> !bus_rvalid && bus_rdata == 0)
    else $error("stray read data");
  cnt_lo_rd_a: assert property (bus_rd && bus_sel == 3'h0 |=>
    bus_rdata == $past(timer_count_value[7:0])) else $error("count low");
  cmpa_hi_rd_a: assert property (bus_rd && bus_sel == 3'h3 |=>
    bus_rdata == $past(compare_value_a[15:8])) else $error("cmp a high");
  cmpb_hi_rd_a: assert property (bus_rd && bus_sel == 3'h5 |=>
    bus_rdata == $past(compare_value_b[15:8])) else $error("cmp b high");
  cnt_lo_wr_a: assert property (bus_wr && bus_sel == 3'h0 |=>
    cnt_write_pulse && timer_count_value[7:0] == $past(bus_wdata))
    else $error("count write");
  cmpa_lo_wr_a: assert property (bus_wr && bus_sel == 3'h2 |=>
    compare_value_a[7:0] == $past(bus_wdata)) else $error("cmp a write");
  hi_wr_hold_a: assert property (bus_wr && bus_sel[0] |=>
    $stable(compare_value_a) && $stable(compare_value_b))
    else $error("high write moved a compare");
  pulse_cause_a: assert property (cnt_write_pulse |->
    $past(bus_wr && bus_sel == 3'h0)) else $error("stray pulse");
  cover property (bus_rd && bus_sel == 3'h1);
  cover property (bus_wr && bus_sel == 3'h6);
  cover property (cnt_write_pulse);
endmodule

/* verification/wtb_cpu.sv */
// cpu side model making byte accesses
// assumes the bridge samples strobes on rising clk
`timescale 1ns/1ns
// =====
// cpu model
module wtb_cpu (
  input  logic       clk,
  output logic       bus_wr,
  output logic       bus_rd,
  output logic [2:0] bus_sel,
  output logic [7:0] bus_wdata,
  input  logic [7:0] bus_rdata
);
  initial {bus_wr, bus_rd, bus_sel, bus_wdata} = 13'h0000;
  // one byte access, strobe for one cycle
  task acc(input logic w, input logic [2:0] s, input logic [7:0] d,
           output logic [7:0] r);
    @(posedge clk);
    bus_wr <= w;
    bus_rd <= !w;
    bus_sel <= s;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_wdata <= ~d; // released byte shows no stale value
    @(negedge clk);
    r = bus_rdata; // settled mid cycle while it stands
  endtask
  // high byte first, never split by another access
  task wr16(input logic [2:0] s, input logic [15:0] d);
    logic [7:0] r;
    acc(1'b1, s + 3'h1, d[15:8], r);
    acc(1'b1, s, d[7:0], r);
  endtask
  // low byte first
  task rd16(input logic [2:0] s, output logic [15:0] d);
    acc(1'b0, s, 8'h00, d[7:0]);
    acc(1'b0, s + 3'h1, 8'h00, d[15:8]);
  endtask
endmodule

/* verification/wtb_wide_timer_byte_access_tb.sv */
// bench for the byte access bridge
// assumes the cpu model and checker are compiled first
`timescale 1ns/1ns
// =====
// bench
module wtb_wide_timer_byte_access_tb;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        bus_wr, bus_rd, bus_rvalid, cnt_write_pulse;
  logic        core_cnt_load = 1'b0, core_cap_load = 1'b0;
  logic [2:0]  bus_sel;
  logic [7:0]  bus_wdata, bus_rdata, t;
  logic [15:0] core_cnt_value = 16'h0000, core_cap_value = 16'h0000;
  logic [15:0] timer_count_value, compare_value_a, compare_value_b;
  logic [15:0] capture_value, v;
  int          fails = 0, comparisons = 0;
  logic [18:0] rows [4] = '{{3'h0, 16'h01ff}, {3'h2, 16'h8000},
                            {3'h4, 16'hffff}, {3'h6, 16'h00a5}};
  wtb_wide_timer_byte_access #(.WIDTH(16)) dut_u (.*);
  wtb_cpu cpu_u (.*);
  // free running clock
  always #5 clk = ~clk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chk(timer_count_value | compare_value_a | capture_value, 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      cpu_u.wr16(rows[i][18:16], rows[i][15:0]);
      cpu_u.rd16(rows[i][18:16], v);
      chk(v, rows[i][15:0]);
    end
    $display("row test done");
    cpu_u.acc(1'b1, 3'h3, 8'h5a, t);
    chk(compare_value_a, 16'h8000);
    cpu_u.acc(1'b1, 3'h6, 8'h33, t);
    chk(capture_value, 16'h5a33);
    @(posedge clk);
    core_cnt_load <= 1'b1;
    core_cnt_value <= 16'h1234;
    core_cap_load <= 1'b1;
    core_cap_value <= 16'hbeef;
    @(posedge clk);
    core_cnt_load <= 1'b0;
    core_cap_load <= 1'b0;
    cpu_u.acc(1'b0, 3'h0, 8'h00, t);
    chk({8'h00, t}, 16'h0034);
    cpu_u.rd16(3'h2, v);
    chk(v, 16'h8000);
    cpu_u.acc(1'b0, 3'h1, 8'h00, t);
    chk({8'h00, t}, 16'h0012);
    cpu_u.rd16(3'h6, v);
    chk(v, 16'hbeef);
    $display("hand test done");
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk(timer_count_value | compare_value_a, 16'h0000);
    chk(compare_value_b | capture_value, 16'h0000);
    chk({6'h00, bus_rdata, bus_rvalid, cnt_write_pulse}, 16'h0000);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cpu_u.acc(1'b1, 3'h0, 8'h77, t);
    chk(timer_count_value, 16'h0077);
    chk({15'h0000, cnt_write_pulse}, 16'h0001);
    cpu_u.acc(1'b0, 3'h4, 8'h00, t);
    chk({15'h0000, bus_rvalid}, 16'h0001);
    chk({8'h00, t}, 16'h0000);
    $display("mid run reset test done");
    conclude;
  end
  // watchdog against a hung sequence
  initial begin
    #20000;
    fails++;
    conclude;
  end
endmodule
bind wtb_wide_timer_byte_access wtb_chk #(.WIDTH(WIDTH)) chk_u (.*);
